// >>> logic/accel_sample_readout_regs.sv
/*
 * accelerometer readout registers: status, output data, byte order and
 * alignment, motion event configuration and interrupt combination.
 * assumes samples and threshold comparisons arrive from the sensing chain,
 * and a host port with one-cycle strobes and read data a cycle later.
 */
// The strobed register port was decided locally.
// Operation
// - reading the filter-clear address zeroes the high-pass filter state
// - status upper nibble: any-enabled-axis overrun, then z, y, x overrun
// - status lower nibble: all-enabled-axes new data, then z, y, x new data
// - status refreshes each sample period, independent of update inhibit
// - default order returns low byte at first address of axis pair
// - default order returns high byte at second address of axis pair
// - big-endian swaps each pair, high byte shaped by alignment first
// - 12-bit mode fills bits 15 to 12 with copies of bit 11
// - config bits: combination, latch, z/y/x high and low enables
// - combination 0 means any enabled event, 1 means all together
// - latch 1 holds the motion request, 0 follows the live condition
// - high enable requests interrupt when axis exceeds threshold
// - low enable requests interrupt when axis falls below threshold
// - motion event configuration resets to zero
// - in latch mode, reading acknowledge address refreshes event source
// - alignment 0 gives 12-bit right justified, 1 gives 16-bit left
// - byte order select resets to 0, little endian
`timescale 1ns/1ns
`default_nettype none
module accel_sample_readout_regs
    import accel_readout_pkg::*;
#(
    parameter int SAMPLE_PERIOD = SAMPLE_PERIOD_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // host register port
    input wire accel_readout_pkg::byte_t reg_addr,
    input wire accel_readout_pkg::byte_t reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output accel_readout_pkg::byte_t reg_rdata,
    // sensing chain: raw 12-bit samples per axis, x in low bits
    input wire logic [3*SAMPLE_WIDTH-1:0] raw_samples,
    input wire logic [2:0] axis_enable,
    // threshold comparisons per axis: {z,y,x}
    input wire logic [2:0] above_threshold,
    input wire logic [2:0] below_threshold,
    // sensing chain controls
    output logic highpass_clear,
    output logic sample_taken,
    // interrupt
    output logic irq
);
    localparam int W = 16;

    byte_t motion_event_config_ff;
    byte_t control_two_ff;
    byte_t motion_event_source_ff;
    byte_t reg_rdata_ff;
    logic [IRQ_BITS-1:0] irq_status_ff;
    logic [IRQ_BITS-1:0] irq_enable_ff;
    logic [31:0] period_cnt_ff;
    logic sample_tick;
    logic [W-1:0] held [3];
    logic [2:0] new_data;
    logic [2:0] overrun;
    logic [5:0] event_live;
    logic [5:0] event_enable;
    logic motion_live;
    logic motion_req;
    logic rd_low_pair [3];
    logic rd_high_pair [3];
    logic all_new;
    logic all_ovr;
    logic inhibit;
    logic swap;
    logic align16;
    byte_t status_byte;

    assign inhibit = control_two_ff[BLOCK_UPDATE_INHIBIT_BIT];
    assign swap = control_two_ff[BYTE_ORDER_SELECT_BIT];
    assign align16 = control_two_ff[ALIGNMENT_SELECT_BIT];

    // sample period divider: one-cycle tick each output period
    always_ff @(posedge sys_clk) begin
        if (reset || period_cnt_ff == 32'(SAMPLE_PERIOD - 1)) begin
            period_cnt_ff <= '0;
        end else begin
            period_cnt_ff <= period_cnt_ff + 32'd1;
        end
    end
    assign sample_tick = !reset && period_cnt_ff == 32'(SAMPLE_PERIOD - 1);
    assign sample_taken = sample_tick;

    // per-axis slots; an address read hits the low or high byte of the pair
    for (genvar a = 0; a < 3; a++) begin : g_axis
        logic [W-1:0] shaped;
        logic [SAMPLE_WIDTH-1:0] raw;
        assign raw = raw_samples[a*SAMPLE_WIDTH +: SAMPLE_WIDTH];
        // 16-bit left justified or 12-bit sign extended
        assign shaped = align16 ? {raw, 4'h0}
                                : {{4{raw[SAMPLE_WIDTH-1]}}, raw};
        assign rd_low_pair[a] = reg_read && reg_addr == byte_t'(ACCEL_X_LOW_ADDR + 2*a);
        assign rd_high_pair[a] = reg_read && reg_addr == byte_t'(ACCEL_X_HIGH_ADDR + 2*a);
        axis_sample_slot #(
            .WIDTH(W)
        ) u_slot (
            .sys_clk(sys_clk),
            .reset(reset),
            .sample_stb(sample_tick && axis_enable[a]),
            .sample_in(shaped),
            .inhibit(inhibit),
            .read_low(rd_low_pair[a]),
            .read_high(rd_high_pair[a]),
            .held_ff(held[a]),
            .new_data_ff(new_data[a]),
            .overrun_ff(overrun[a])
        );
    end

    // combined flags over enabled axes
    assign all_new = axis_enable != 3'h0 && (new_data | ~axis_enable) == 3'h7;
    assign all_ovr = |(overrun & axis_enable);

    // status shows the axis flags, which the tick sets whatever the inhibit;
    // a copy would lag the tick by one period
    assign status_byte = {all_ovr, overrun, all_new, new_data};

    // software-written registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            motion_event_config_ff <= MOTION_EVENT_CONFIG_RST;
            control_two_ff <= CONTROL_TWO_RST;
            irq_enable_ff <= '0;
        end else if (reg_write) begin
            case (reg_addr)
                MOTION_EVENT_CONFIG_ADDR: motion_event_config_ff <= reg_wdata;
                CONTROL_TWO_ADDR: control_two_ff <= reg_wdata;
                IRQ_ENABLE_ADDR: irq_enable_ff <= reg_wdata[IRQ_BITS-1:0];
                default: ;
            endcase
        end
    end

    // live events {zh,zl,yh,yl,xh,xl} against enables
    for (genvar a = 0; a < 3; a++) begin : g_event
        assign event_live[2*a+1] = above_threshold[a];
        assign event_live[2*a] = below_threshold[a];
    end
    assign event_enable = motion_event_config_ff[5:0];
    // and/or combination over enabled events
    assign motion_live = motion_event_config_ff[COMBINATION_BIT]
        ? (event_enable != 6'h00 && (event_live & event_enable) == event_enable)
        : |(event_live & event_enable);

    // event source: latched until acknowledge read, else live
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            motion_event_source_ff <= 8'h00;
        end else if (!motion_event_config_ff[LATCH_BIT]) begin
            motion_event_source_ff <= {1'b0, motion_live, event_live & event_enable};
        end else if (reg_read && reg_addr == MOTION_ACKNOWLEDGE_ADDR) begin
            motion_event_source_ff <= {1'b0, motion_live, event_live & event_enable};
        end else if (motion_live) begin
            motion_event_source_ff <= motion_event_source_ff
                | {1'b0, 1'b1, event_live & event_enable};
        end
    end
    assign motion_req = motion_event_source_ff[6];

    // filter clear pulse on read of its address
    assign highpass_clear = reg_read && reg_addr == HIGHPASS_CLEAR_ADDR;

    // sticky interrupt status; set wins over clear
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_status_ff <= '0;
        end else begin
            irq_status_ff <= (irq_status_ff
                & ~((reg_write && reg_addr == IRQ_CLEAR_ADDR) ? reg_wdata[IRQ_BITS-1:0] : 3'h0))
                | {motion_req, all_ovr, all_new};
        end
    end
    assign irq = |(irq_status_ff & irq_enable_ff);

    // read data, one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                SAMPLE_STATUS_ADDR: reg_rdata_ff <= status_byte;
                ACCEL_X_LOW_ADDR: reg_rdata_ff <= swap ? held[0][15:8] : held[0][7:0];
                ACCEL_X_HIGH_ADDR: reg_rdata_ff <= swap ? held[0][7:0] : held[0][15:8];
                ACCEL_Y_LOW_ADDR: reg_rdata_ff <= swap ? held[1][15:8] : held[1][7:0];
                ACCEL_Y_HIGH_ADDR: reg_rdata_ff <= swap ? held[1][7:0] : held[1][15:8];
                ACCEL_Z_LOW_ADDR: reg_rdata_ff <= swap ? held[2][15:8] : held[2][7:0];
                ACCEL_Z_HIGH_ADDR: reg_rdata_ff <= swap ? held[2][7:0] : held[2][15:8];
                MOTION_EVENT_CONFIG_ADDR: reg_rdata_ff <= motion_event_config_ff;
                MOTION_EVENT_SOURCE_ADDR: reg_rdata_ff <= motion_event_source_ff;
                CONTROL_TWO_ADDR: reg_rdata_ff <= control_two_ff;
                IRQ_STATUS_ADDR: reg_rdata_ff <= {5'h00, irq_status_ff};
                IRQ_ENABLE_ADDR: reg_rdata_ff <= {5'h00, irq_enable_ff};
                default: reg_rdata_ff <= 8'h00; // dummy and unmapped read zero
            endcase
        end
    end
    assign reg_rdata = reg_rdata_ff;
endmodule : accel_sample_readout_regs
`default_nettype wire

// >>> logic/accel_readout_pkg.sv
/*
 * shared constants of the accelerometer readout register block: register
 * offsets, field positions, reset values and rate timing.
 * assumes a single 20 MHz clock and an 8-bit register address space.
 */
`default_nettype none
package accel_readout_pkg;
    typedef logic [7:0] byte_t;
    // register offsets
    localparam byte_t HIGHPASS_CLEAR_ADDR = 8'h23;
    localparam byte_t SAMPLE_STATUS_ADDR = 8'h27;
    localparam byte_t ACCEL_X_LOW_ADDR = 8'h28;
    localparam byte_t ACCEL_X_HIGH_ADDR = 8'h29;
    localparam byte_t ACCEL_Y_LOW_ADDR = 8'h2A;
    localparam byte_t ACCEL_Y_HIGH_ADDR = 8'h2B;
    localparam byte_t ACCEL_Z_LOW_ADDR = 8'h2C;
    localparam byte_t ACCEL_Z_HIGH_ADDR = 8'h2D;
    localparam byte_t MOTION_EVENT_CONFIG_ADDR = 8'h30;
    localparam byte_t MOTION_EVENT_SOURCE_ADDR = 8'h31;
    localparam byte_t MOTION_ACKNOWLEDGE_ADDR = 8'h32;
    localparam byte_t CONTROL_TWO_ADDR = 8'h21;
    localparam byte_t IRQ_STATUS_ADDR = 8'h40;
    localparam byte_t IRQ_ENABLE_ADDR = 8'h41;
    localparam byte_t IRQ_CLEAR_ADDR = 8'h42;
    // control_two field positions
    localparam int BLOCK_UPDATE_INHIBIT_BIT = 6;
    localparam int BYTE_ORDER_SELECT_BIT = 5;
    localparam int ALIGNMENT_SELECT_BIT = 0;
    // motion_event_config field positions
    localparam int COMBINATION_BIT = 7;
    localparam int LATCH_BIT = 6;
    // reset values
    localparam byte_t MOTION_EVENT_CONFIG_RST = 8'h00;
    localparam byte_t CONTROL_TWO_RST = 8'h00;
    // irq status bits: data ready, overrun, motion
    localparam int IRQ_DATA_BIT = 0;
    localparam int IRQ_OVERRUN_BIT = 1;
    localparam int IRQ_MOTION_BIT = 2;
    localparam int IRQ_BITS = 3;
    // sample timing: 40 Hz output rate on a 20 MHz clock
    localparam int CLOCK_HZ = 20000000;
    localparam int SAMPLE_RATE_HZ = 40;
    localparam int SAMPLE_PERIOD_CYCLES = CLOCK_HZ / SAMPLE_RATE_HZ;
    localparam int SAMPLE_WIDTH = 12;
endpackage : accel_readout_pkg
`default_nettype wire

// >>> logic/axis_sample_slot.sv
/*
 * one axis: holds the latest sample, keeps new-data and overrun flags and
 * freezes the held sample between the two byte reads when asked.
 * assumes the sample strobe and read pulses are synchronous to sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module axis_sample_slot #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // sample input
    input wire logic sample_stb,
    input wire logic [WIDTH-1:0] sample_in,
    // host access
    input wire logic inhibit,
    input wire logic read_low,
    input wire logic read_high,
    // state
    output logic [WIDTH-1:0] held_ff,
    output logic new_data_ff,
    output logic overrun_ff
);
    logic open_low_ff;    // low byte read first under inhibit, high pending
    logic open_high_ff;   // high byte read first under inhibit, low pending
    logic [WIDTH-1:0] pend_ff;
    logic pend_valid_ff;
    logic load_ok;
    logic take;

    // frozen while a pair is half read under inhibit, or read this cycle,
    // so a sample landing beside a byte read cannot split the pair
    assign load_ok = !(inhibit && (open_low_ff || open_high_ff || read_low || read_high));
    assign take = load_ok && (sample_stb || pend_valid_ff);

    // held value with deferred update while frozen
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            held_ff <= '0;
            pend_ff <= '0;
            pend_valid_ff <= 1'b0;
        end else if (take) begin
            held_ff <= sample_stb ? sample_in : pend_ff;
            pend_valid_ff <= 1'b0;
        end else if (sample_stb) begin
            pend_ff <= sample_in;
            pend_valid_ff <= 1'b1;
        end
    end

    // pair tracking: one byte opens, the other byte closes; cleared while
    // inhibit is off so no stale half-read survives into inhibit mode
    always_ff @(posedge sys_clk) begin
        if (reset || !inhibit) begin
            open_low_ff <= 1'b0;
            open_high_ff <= 1'b0;
        end else if (read_low) begin
            open_low_ff <= !open_high_ff;
            open_high_ff <= 1'b0;
        end else if (read_high) begin
            open_high_ff <= !open_low_ff;
            open_low_ff <= 1'b0;
        end
    end

    // flags: fresh sample sets, read clears; set wins
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            new_data_ff <= 1'b0;
            overrun_ff <= 1'b0;
        end else if (sample_stb) begin
            new_data_ff <= 1'b1;
            overrun_ff <= new_data_ff ? 1'b1 : overrun_ff;
        end else if (read_low || read_high) begin
            new_data_ff <= 1'b0;
            overrun_ff <= 1'b0;
        end
    end
endmodule : axis_sample_slot
`default_nettype wire

// >>> verification/accel_sense_model.sv
/* sensing chain stand-in: presents the bench's sample levels as raw samples.
   assumes the bench changes the level away from the clock edge. */
`timescale 1ns/1ns
`default_nettype none
module accel_sense_model (
    // clock
    input wire logic sys_clk,
    // levels from the bench, {z,y,x}
    input wire logic [35:0] level,
    // raw samples to the block
    output logic [35:0] raw_samples
);
    // register the level so samples change only just after an edge
    always_ff @(posedge sys_clk) begin
        raw_samples <= level;
    end
endmodule : accel_sense_model
`default_nettype wire

// >>> verification/accel_readout_assertions.sv
/* port-level checker of the readout registers.
   assumes it is bound to accel_sample_readout_regs. */
`timescale 1ns/1ns
`default_nettype none
module accel_readout_checker
    import accel_readout_pkg::*;
#(
    parameter int SAMPLE_PERIOD = SAMPLE_PERIOD_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // host port
    input wire accel_readout_pkg::byte_t reg_addr,
    input wire accel_readout_pkg::byte_t reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire accel_readout_pkg::byte_t reg_rdata,
    // outputs
    input wire logic highpass_clear,
    input wire logic sample_taken,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    int gap_ff;
    logic seen_ff;
    // cycles since the last sample tick
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            gap_ff <= 0;
            seen_ff <= 1'b0;
        end else begin
            gap_ff <= sample_taken ? 0 : gap_ff + 1;
            seen_ff <= seen_ff | sample_taken;
        end
    end
    a_clear_on_read: assert property (reg_read && reg_addr == 8'h23 |-> highpass_clear)
        else $error("filter clear missing");
    a_clear_only_read: assert property (highpass_clear |-> reg_read && reg_addr == 8'h23)
        else $error("stray filter clear");
    a_tick_period: assert property (sample_taken && seen_ff |-> gap_ff == SAMPLE_PERIOD - 1)
        else $error("sample tick spacing wrong");
    a_rdata_holds: assert property (!$past(reg_read) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (reg_read && reg_addr == 8'h50 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_config_back: assert property ((reg_write && reg_addr == 8'h30) ##2
        (reg_read && reg_addr == 8'h30) |=> reg_rdata == $past(reg_wdata, 3))
        else $error("motion config readback wrong");
    a_flags_clear: assert property ((reg_read && reg_addr == 8'h29 && !sample_taken) ##1
        !sample_taken ##1 (reg_read && reg_addr == 8'h27 && !sample_taken)
        |=> reg_rdata[0] == 1'b0 && reg_rdata[3] == 1'b0)
        else $error("x new data not cleared by read");
    a_mask_drops_irq: assert property (reg_write && reg_addr == 8'h41 && reg_wdata == 8'h00
        |=> !irq)
        else $error("irq high with all sources masked");
    c_tick: cover property (sample_taken);
    c_ack: cover property (reg_read && reg_addr == 8'h32);
    c_irq: cover property (irq);
endmodule : accel_readout_checker
bind accel_sample_readout_regs accel_readout_checker #(.SAMPLE_PERIOD(SAMPLE_PERIOD))
    u_accel_readout_checker (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .highpass_clear(highpass_clear),
    .sample_taken(sample_taken), .irq(irq));
`default_nettype wire

// >>> verification/tb_top.sv
/* self-checking bench of the readout registers over the host port.
   assumes a short sample period so ticks come every 64 cycles. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import accel_readout_pkg::*;
    localparam int PERIOD = 64;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    byte_t reg_addr = 8'h00;
    byte_t reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [35:0] level = {12'h123, 12'h7FF, 12'h800};
    logic [2:0] axis_enable = 3'b111;
    logic [2:0] above_threshold = 3'b000;
    logic [2:0] below_threshold = 3'b000;
    byte_t reg_rdata;
    logic [35:0] raw_samples;
    logic highpass_clear, sample_taken, irq;
    int num_errors = 0;
    int n_compared = 0;
    accel_sense_model u_accel_sense_model (.sys_clk(sys_clk), .level(level),
        .raw_samples(raw_samples));
    accel_sample_readout_regs #(.SAMPLE_PERIOD(PERIOD)) u_accel_sample_readout_regs (
        .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .raw_samples(raw_samples), .axis_enable(axis_enable),
        .above_threshold(above_threshold), .below_threshold(below_threshold),
        .highpass_clear(highpass_clear), .sample_taken(sample_taken), .irq(irq));
    // 50 ns clock
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string what, input byte_t exp, input byte_t got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input byte_t a, input byte_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : wr
    // read, then compare the masked byte just after the edge that registers it
    task automatic rdc(input byte_t a, input byte_t exp, input byte_t mask);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp & mask, reg_rdata & mask);
    endtask : rdc
    task automatic wait_tick;
        int i;
        for (i = 0; i < 4 * PERIOD; i++) begin
            @(negedge sys_clk);
            if (sample_taken === 1'b1) break;
        end
        if (i == 4 * PERIOD) begin
            num_errors++;
            $display("CHECK FAILED sample tick expected 1 seen 0");
            test_done();
        end
        @(posedge sys_clk);
    endtask : wait_tick
    task automatic irq_is(input logic exp);
        repeat (3) @(posedge sys_clk);
        #1;
        chk("irq", {7'h00, exp}, {7'h00, irq});
    endtask : irq_is
    // main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        rdc(8'h30, 8'h00, 8'hFF);
        rdc(8'h21, 8'h00, 8'hFF);
        rdc(8'h50, 8'h00, 8'hFF);
        wr(8'h30, 8'hA5);
        rdc(8'h30, 8'hA5, 8'hFF);
        wr(8'h30, 8'h00);
        rdc(8'h23, 8'h00, 8'h00);
        $display("test registers done");
        wait_tick();
        rdc(8'h27, 8'h0F, 8'h0F);
        rdc(8'h2C, 8'h23, 8'hFF);
        rdc(8'h2D, 8'h01, 8'hFF);
        rdc(8'h2A, 8'hFF, 8'hFF);
        rdc(8'h2B, 8'h07, 8'hFF);
        rdc(8'h28, 8'h00, 8'hFF);
        rdc(8'h29, 8'hF8, 8'hFF);
        rdc(8'h27, 8'h00, 8'h0F);
        wait_tick();
        wait_tick();
        rdc(8'h27, 8'hFF, 8'hFF);
        $display("test samples done");
        wr(8'h21, 8'h01);
        wait_tick();
        rdc(8'h28, 8'h00, 8'hFF);
        rdc(8'h29, 8'h80, 8'hFF);
        rdc(8'h2B, 8'h7F, 8'hFF);
        wr(8'h21, 8'h20);
        wait_tick();
        rdc(8'h28, 8'hF8, 8'hFF);
        rdc(8'h2D, 8'h23, 8'hFF);
        wr(8'h21, 8'h40);
        wait_tick();
        level <= {12'h123, 12'h7FF, 12'h456};
        rdc(8'h28, 8'h00, 8'hFF);
        wait_tick();
        rdc(8'h27, 8'h01, 8'h01);
        rdc(8'h29, 8'hF8, 8'hFF);
        rdc(8'h28, 8'h56, 8'hFF);
        wr(8'h21, 8'h00);
        axis_enable <= 3'b011;
        wait_tick();
        rdc(8'h2C, 8'h23, 8'hFF);
        rdc(8'h27, 8'h0B, 8'h0F);
        axis_enable <= 3'b111;
        $display("test formats done");
        wr(8'h41, 8'h04);
        wr(8'h30, 8'h02);
        above_threshold <= 3'b001;
        irq_is(1'b1);
        above_threshold <= 3'b000;
        wr(8'h42, 8'h07);
        irq_is(1'b0);
        wr(8'h30, 8'h01);
        below_threshold <= 3'b001;
        rdc(8'h31, 8'h41, 8'h7F);
        below_threshold <= 3'b000;
        wr(8'h30, 8'h8A);
        above_threshold <= 3'b001;
        rdc(8'h31, 8'h00, 8'h40);
        above_threshold <= 3'b011;
        rdc(8'h31, 8'h40, 8'h40);
        above_threshold <= 3'b000;
        wr(8'h30, 8'h42);
        above_threshold <= 3'b001;
        repeat (3) @(posedge sys_clk);
        above_threshold <= 3'b000;
        rdc(8'h31, 8'h40, 8'h40);
        rdc(8'h32, 8'h00, 8'h00);
        rdc(8'h31, 8'h00, 8'h40);
        wr(8'h30, 8'h02);
        above_threshold <= 3'b001;
        repeat (3) @(posedge sys_clk);
        above_threshold <= 3'b000;
        rdc(8'h31, 8'h00, 8'h40);
        wr(8'h41, 8'h00);
        $display("test motion done");
        test_done();
    end
endmodule : tb_top
`default_nettype wire
